/* File: hdl/ppc_defines.vh */
// Constants for the port two / port three control register bank.
// Assumes a single 40 MHz system clock and the serial front end's write strobe.
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH

// Register and port addresses as seen on the serial front end
`define PPC_REG_ADDR_W 3
`define PPC_REG_PORT_CTRL 3'h2
`define PPC_PORT_ADDR_W 3
`define PPC_PORT_TWO 3'h1
`define PPC_PORT_THREE 3'h2

// Control byte field positions
`define PPC_BIT_FAULT_DIS 7
`define PPC_BIT_SPARE 6
`define PPC_BIT_CLASS_LIM 5
`define PPC_BIT_BLINK 4
`define PPC_BIT_LED_LOW 3
`define PPC_BIT_LED_HIGH 2
`define PPC_MODE_HI 1
`define PPC_MODE_LO 0

// Control byte reset value and writable bits (spare bit masked off)
`define PPC_CTRL_RESET 8'h00
`define PPC_CTRL_WMASK 8'hbf

// Enable mode codes
`define PPC_MODE_OFF 2'h0
`define PPC_MODE_SEQ 2'h1
`define PPC_MODE_SAMPLE 2'h2
`define PPC_MODE_PWR_DOWN 2'h3

// One-hot mode outputs: bit 0 off, 1 sequence, 2 sample, 3 power down
`define PPC_ONEHOT_RESET 4'h1

// Classification current limits in mA
`define PPC_CLASS_SEL_RESET 2'h0
`define PPC_CLASS_MA_00 8'ha0
`define PPC_CLASS_MA_01 8'h50
`define PPC_CLASS_MA_10 8'h28
`define PPC_CLASS_MA_11 8'h14

// Fast blink period: milliseconds = 0.00013 x clock in Hz
`define PPC_CLK_HZ 40000000
`define PPC_BLINK_FACTOR_NUM 13
`define PPC_BLINK_FACTOR_DEN 100000
`define PPC_BLINK_PERIOD_MS (`PPC_CLK_HZ * `PPC_BLINK_FACTOR_NUM / `PPC_BLINK_FACTOR_DEN)
`define PPC_BLINK_PERIOD_CYC (`PPC_BLINK_PERIOD_MS * (`PPC_CLK_HZ / 1000))
`define PPC_BLINK_CNT_W 28

`endif

/* File: hdl/ppc_led_drive.v */
// One port's LED switch drive: blink gating and switch interlock.
// Assumes the blink phase comes from a counter on the same clock.
`timescale 1ns/1ps
`include "ppc_defines.vh"

module ppc_led_drive (
  input wire clk,
  input wire reset,
  input wire blink_en,
  input wire low_en,
  input wire high_en,
  input wire blink_phase,
  output reg low_on_r,
  output reg high_on_r
);

  wire gate;
  wire low_nxt;
  wire high_nxt;

  assign gate = ~blink_en | blink_phase;
  assign low_nxt = low_en & gate;
  assign high_nxt = high_en & ~low_en & gate;

  always @(posedge clk) begin
    if (reset) begin
      low_on_r <= 1'b0;
      high_on_r <= 1'b0;
    end else begin
      low_on_r <= low_nxt;
      high_on_r <= high_nxt;
    end
  end

endmodule // ppc_led_drive

/* File: hdl/ppc_port_ctrl_regs.v */
// Write-only control registers of ports two and three, with their decoded controls.
// Assumes the serial front end presents each decoded write as a one-cycle strobe
// on the system clock, together with register address, port address and data.
`timescale 1ns/1ps
`include "ppc_defines.vh"

// How it works
// - Bit 7 set disables the port's overload and under/overvoltage timers.
// - Port three bit 5 is limit high bit, port two bit 5 low bit.
// - Limit code 00/01/10/11 selects 160/80/40/20 mA classification current.
// - Bit 4 set blinks the enabled LED drive, otherwise it stays on.
// - Blink period in ms equals 0.00013 times the clock frequency.
// - Bit 3 set turns on the low-side LED switch.
// - Bit 2 set, with bit 3 clear, turns on the high-side LED switch to the rail.
// - Mode 00 turns the port off, 01 starts discovery-classification-power.
// - Mode 10 samples powered current, 11 powers down an active port.
module ppc_port_ctrl_regs #(
  parameter [`PPC_BLINK_CNT_W-1:0] BLINK_PERIOD_CYC = `PPC_BLINK_PERIOD_CYC
) (
  input wire CLK_SYS,
  input wire RESET,
  input wire WR_STB,
  input wire [`PPC_REG_ADDR_W-1:0] REG_ADDR,
  input wire [`PPC_PORT_ADDR_W-1:0] PORT_ADDR,
  input wire [7:0] WR_DATA,
  output wire P2_FAULT_TMR_DIS,
  output wire P3_FAULT_TMR_DIS,
  output wire P2_LED_LOW_ON,
  output wire P2_LED_HIGH_ON,
  output wire P3_LED_LOW_ON,
  output wire P3_LED_HIGH_ON,
  output wire [3:0] P2_MODE_DEC,
  output wire [3:0] P3_MODE_DEC,
  output wire P2_MODE_WR,
  output wire P3_MODE_WR,
  output wire [1:0] CLASS_LIMIT_SEL,
  output reg [7:0] CLASS_LIMIT_MA
);

  // Half period sets the toggle; a period under two cycles still toggles each cycle
  localparam [`PPC_BLINK_CNT_W-1:0] BLINK_HALF_CYC =
    (BLINK_PERIOD_CYC < 2) ? {{(`PPC_BLINK_CNT_W-1){1'b0}}, 1'b1} : (BLINK_PERIOD_CYC >> 1);
  localparam NPORT = 2;

  // Write hit for one port's control register
  function wr_hit;
    input stb;
    input [`PPC_REG_ADDR_W-1:0] reg_addr;
    input [`PPC_PORT_ADDR_W-1:0] port_addr;
    input [`PPC_PORT_ADDR_W-1:0] target;
    begin
      wr_hit = stb && (reg_addr == `PPC_REG_PORT_CTRL) && (port_addr == target);
    end
  endfunction

  // Enable mode code to one-hot command
  function [3:0] mode_onehot;
    input [1:0] code;
    begin
      case (code)
        `PPC_MODE_OFF: mode_onehot = 4'h1;
        `PPC_MODE_SEQ: mode_onehot = 4'h2;
        `PPC_MODE_SAMPLE: mode_onehot = 4'h4;
        `PPC_MODE_PWR_DOWN: mode_onehot = 4'h8;
        default: mode_onehot = 4'h1;
      endcase
    end
  endfunction

  // Common limit code to classification current in mA
  function [7:0] class_ma;
    input [1:0] code;
    begin
      case (code)
        2'h0: class_ma = `PPC_CLASS_MA_00;
        2'h1: class_ma = `PPC_CLASS_MA_01;
        2'h2: class_ma = `PPC_CLASS_MA_10;
        2'h3: class_ma = `PPC_CLASS_MA_11;
        default: class_ma = `PPC_CLASS_MA_00;
      endcase
    end
  endfunction

  reg [1:0] class_sel_r;
  reg [1:0] class_sel_nxt;
  reg [7:0] class_ma_nxt;
  reg [`PPC_BLINK_CNT_W-1:0] blink_cnt_r;
  reg [`PPC_BLINK_CNT_W-1:0] blink_cnt_nxt;
  reg blink_phase_r;
  reg blink_phase_nxt;
  wire blink_wrap;
  wire [NPORT-1:0] hit;
  wire [NPORT-1:0] led_low;
  wire [NPORT-1:0] led_high;
  wire [NPORT-1:0] fault_dis;
  wire [NPORT-1:0] class_bit;
  wire [NPORT-1:0] mode_wr;
  wire [4*NPORT-1:0] mode_dec;

  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : g_port
      wire [`PPC_PORT_ADDR_W-1:0] my_addr;
      wire blink_en;
      wire led_low_en;
      wire led_high_en;
      reg [7:0] ctrl_r;
      reg [7:0] ctrl_nxt;
      reg [3:0] mode_dec_r;
      reg [3:0] mode_dec_nxt;
      reg mode_wr_r;

      assign my_addr = (p == 0) ? `PPC_PORT_TWO : `PPC_PORT_THREE;
      assign hit[p] = wr_hit(WR_STB, REG_ADDR, PORT_ADDR, my_addr);

      // Unaddressed writes leave both the byte and the decoded mode alone
      always @* begin
        ctrl_nxt = ctrl_r;
        mode_dec_nxt = mode_dec_r;
        if (hit[p]) begin
          ctrl_nxt = WR_DATA & `PPC_CTRL_WMASK;
          mode_dec_nxt = mode_onehot(WR_DATA[`PPC_MODE_HI:`PPC_MODE_LO]);
        end
      end

      // Each port owns its registers, so every bit has one driving process
      always @(posedge CLK_SYS) begin
        if (RESET) begin
          ctrl_r <= `PPC_CTRL_RESET;
          mode_dec_r <= `PPC_ONEHOT_RESET;
          mode_wr_r <= 1'b0;
        end else begin
          ctrl_r <= ctrl_nxt;
          mode_dec_r <= mode_dec_nxt;
          // Pulse marks every write, so a repeated command is seen again
          mode_wr_r <= hit[p];
        end
      end

      assign fault_dis[p] = ctrl_r[`PPC_BIT_FAULT_DIS];
      assign class_bit[p] = ctrl_r[`PPC_BIT_CLASS_LIM];
      assign mode_wr[p] = mode_wr_r;
      assign mode_dec[4*p+3:4*p] = mode_dec_r;
      // LED enables from the stored byte
      assign blink_en = ctrl_r[`PPC_BIT_BLINK];
      assign led_low_en = ctrl_r[`PPC_BIT_LED_LOW];
      assign led_high_en = ctrl_r[`PPC_BIT_LED_HIGH];

      ppc_led_drive u_led (
        .clk(CLK_SYS),
        .reset(RESET),
        .blink_en(blink_en),
        .low_en(led_low_en),
        .high_en(led_high_en),
        .blink_phase(blink_phase_r),
        .low_on_r(led_low[p]),
        .high_on_r(led_high[p])
      );
    end
  endgenerate

  assign blink_wrap = (blink_cnt_r >= BLINK_HALF_CYC - {{(`PPC_BLINK_CNT_W-1){1'b0}}, 1'b1});

  // Fast blink timebase, shared by both ports so they blink in step
  always @* begin
    blink_cnt_nxt = blink_cnt_r + {{(`PPC_BLINK_CNT_W-1){1'b0}}, 1'b1};
    blink_phase_nxt = blink_phase_r;
    if (blink_wrap) begin
      blink_cnt_nxt = {`PPC_BLINK_CNT_W{1'b0}};
      blink_phase_nxt = ~blink_phase_r;
    end
  end

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      blink_cnt_r <= {`PPC_BLINK_CNT_W{1'b0}};
      blink_phase_r <= 1'b1;
    end else begin
      blink_cnt_r <= blink_cnt_nxt;
      blink_phase_r <= blink_phase_nxt;
    end
  end

  // Common limit is assembled from the two stored bits, not a separate register
  always @* begin
    class_sel_nxt = {class_bit[1], class_bit[0]};
    class_ma_nxt = class_ma(class_sel_nxt);
  end

  // Limit lags the write by two cycles; both ports' bits land together
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      class_sel_r <= `PPC_CLASS_SEL_RESET;
      CLASS_LIMIT_MA <= `PPC_CLASS_MA_00;
    end else begin
      class_sel_r <= class_sel_nxt;
      CLASS_LIMIT_MA <= class_ma_nxt;
    end
  end

  assign CLASS_LIMIT_SEL = class_sel_r;
  assign P2_FAULT_TMR_DIS = fault_dis[0];
  assign P3_FAULT_TMR_DIS = fault_dis[1];
  assign P2_LED_LOW_ON = led_low[0];
  assign P2_LED_HIGH_ON = led_high[0];
  assign P3_LED_LOW_ON = led_low[1];
  assign P3_LED_HIGH_ON = led_high[1];
  assign P2_MODE_DEC = mode_dec[3:0];
  assign P3_MODE_DEC = mode_dec[7:4];
  assign P2_MODE_WR = mode_wr[0];
  assign P3_MODE_WR = mode_wr[1];

endmodule // ppc_port_ctrl_regs

/* File: sim/ppc_port_ctrl_regs_chk.sv */
// Checker for the port two / port three control register bank.
// Sees only the top module's ports; bound to every instance of it.
`timescale 1ns/1ps

module ppc_port_ctrl_regs_chk #(
  parameter [27:0] BLINK_PERIOD_CYC = 28'h8
) (
  input wire CLK_SYS,
  input wire RESET,
  input wire WR_STB,
  input wire [2:0] REG_ADDR,
  input wire [2:0] PORT_ADDR,
  input wire [7:0] WR_DATA,
  input wire P2_FAULT_TMR_DIS,
  input wire P3_FAULT_TMR_DIS,
  input wire P2_LED_LOW_ON,
  input wire P2_LED_HIGH_ON,
  input wire P3_LED_LOW_ON,
  input wire P3_LED_HIGH_ON,
  input wire [3:0] P2_MODE_DEC,
  input wire [3:0] P3_MODE_DEC,
  input wire P2_MODE_WR,
  input wire P3_MODE_WR,
  input wire [1:0] CLASS_LIMIT_SEL,
  input wire [7:0] CLASS_LIMIT_MA
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  wire w2 = WR_STB && REG_ADDR == 3'h2 && PORT_ADDR == 3'h1;
  wire w3 = WR_STB && REG_ADDR == 3'h2 && PORT_ADDR == 3'h2;

  fault_dis_a: assert property (w2 |=> P2_FAULT_TMR_DIS == $past(WR_DATA[7]))
    else $error("port two timer disable wrong");
  p3_mode_a: assert property (w3 |=> P3_MODE_DEC == 4'h1 << $past(WR_DATA[1:0]))
    else $error("port three mode decode wrong");
  mode_pulse_a: assert property (P2_MODE_WR == $past(w2))
    else $error("port two mode pulse wrong");
  p3_pulse_a: assert property (P3_MODE_WR == $past(w3))
    else $error("port three mode pulse wrong");
  p2_mode_a: assert property (w2 |=> P2_MODE_DEC == 4'h1 << $past(WR_DATA[1:0]))
    else $error("port two mode decode wrong");
  p3_fault_a: assert property (w3 |=> P3_FAULT_TMR_DIS == $past(WR_DATA[7]))
    else $error("port three timer disable wrong");
  class_hi_a: assert property (w3 |=> ##1 CLASS_LIMIT_SEL[1] == $past(WR_DATA[5], 2))
    else $error("limit high bit wrong");
  class_lo_a: assert property (w2 |=> ##1 CLASS_LIMIT_SEL[0] == $past(WR_DATA[5], 2))
    else $error("limit low bit wrong");
  class_ma_a: assert property (CLASS_LIMIT_MA == (CLASS_LIMIT_SEL == 2'h0 ? 8'ha0 :
    CLASS_LIMIT_SEL == 2'h1 ? 8'h50 : CLASS_LIMIT_SEL == 2'h2 ? 8'h28 : 8'h14))
    else $error("limit current wrong");
  p2_interlock_a: assert property (!(P2_LED_LOW_ON && P2_LED_HIGH_ON))
    else $error("port two both switches on");
  p3_interlock_a: assert property (!(P3_LED_LOW_ON && P3_LED_HIGH_ON))
    else $error("port three both switches on");
  bad_addr_a: assert property (WR_STB && REG_ADDR != 3'h2 |=>
    $stable(P2_MODE_DEC) && $stable(P3_MODE_DEC) && !P2_MODE_WR && !P3_MODE_WR)
    else $error("foreign write changed a port");
endmodule // ppc_port_ctrl_regs_chk

bind ppc_port_ctrl_regs ppc_port_ctrl_regs_chk #(.BLINK_PERIOD_CYC(BLINK_PERIOD_CYC)) chk_i (.*);

/* File: sim/tb.sv */
// Self-checking bench for the port two / port three control register bank.
// Drives the write strobe port directly; blink period shortened to 8 cycles.
`timescale 1ns/1ps

module tb;
  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  logic WR_STB = 1'b0;
  logic [2:0] REG_ADDR = 3'h0;
  logic [2:0] PORT_ADDR = 3'h0;
  logic [7:0] WR_DATA = 8'h00;
  wire P2_FAULT_TMR_DIS, P3_FAULT_TMR_DIS, P2_MODE_WR, P3_MODE_WR;
  wire P2_LED_LOW_ON, P2_LED_HIGH_ON, P3_LED_LOW_ON, P3_LED_HIGH_ON;
  wire [3:0] P2_MODE_DEC, P3_MODE_DEC;
  wire [1:0] CLASS_LIMIT_SEL;
  wire [7:0] CLASS_LIMIT_MA;
  int mismatches = 0;
  int tests_run = 0;
  int i, p;
  logic [7:0] ma [4] = '{8'ha0, 8'h50, 8'h28, 8'h14};
  logic [7:0] ld [5] = '{8'h08, 8'h04, 8'h0c, 8'h80, 8'h40};
  logic [2:0] lf [5] = '{3'h2, 3'h1, 3'h2, 3'h4, 3'h0};

  ppc_port_ctrl_regs #(.BLINK_PERIOD_CYC(28'h8)) ppc_port_ctrl_regs_i (.*);

  initial forever #12.5 CLK_SYS = ~CLK_SYS;

  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task ck(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // Strobe held for one taking edge, then outputs given time to settle
  task wr(input logic [2:0] r, input logic [2:0] pa, input logic [7:0] d);
    @(posedge CLK_SYS);
    WR_STB <= 1'b1;
    REG_ADDR <= r;
    PORT_ADDR <= pa;
    WR_DATA <= d;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    #1;
  endtask

  task pt(input bit p3, input logic [3:0] md, input logic [2:0] fl);
    ck("mode", {4'h0, md}, p3 ? {4'h0, P3_MODE_DEC} : {4'h0, P2_MODE_DEC});
    ck("flags", {5'h0, fl}, p3 ? {5'h0, P3_FAULT_TMR_DIS, P3_LED_LOW_ON, P3_LED_HIGH_ON}
      : {5'h0, P2_FAULT_TMR_DIS, P2_LED_LOW_ON, P2_LED_HIGH_ON});
  endtask

  // Switch-on cycles and level changes over one blink period
  task bl(input logic [2:0] pa, input logic [7:0] d, input logic [7:0] e, input logic [7:0] et);
    logic [7:0] n;
    logic [7:0] t;
    logic [7:0] s;
    logic [7:0] q;
    wr(3'h2, pa, d);
    n = 8'h00;
    t = 8'h00;
    q = P2_LED_HIGH_ON + P2_LED_LOW_ON + P3_LED_HIGH_ON + P3_LED_LOW_ON;
    repeat (8) begin
      @(posedge CLK_SYS);
      #1;
      s = P2_LED_HIGH_ON + P2_LED_LOW_ON + P3_LED_HIGH_ON + P3_LED_LOW_ON;
      n = n + s;
      if (s != q) t = t + 8'h01;
      q = s;
    end
    ck("blink", e, n);
    ck("toggles", et, t);
  endtask

  initial begin
    repeat (3000) @(posedge CLK_SYS);
    mismatches++;
    print_verdict;
  end

  initial begin
    repeat (12) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
    #1;
    pt(0, 4'h1, 3'h0);
    pt(1, 4'h1, 3'h0);
    ck("ma", 8'ha0, CLASS_LIMIT_MA);
    for (i = 0; i < 4; i++) begin
      wr(3'h2, 3'h1, i[7:0]);
      wr(3'h2, 3'h2, i[7:0]);
      pt(0, 4'h1 << i[1:0], 3'h0);
      pt(1, 4'h1 << i[1:0], 3'h0);
    end
    for (i = 0; i < 4; i++) begin
      wr(3'h2, 3'h1, {2'h0, i[0], 5'h0});
      wr(3'h2, 3'h2, {2'h0, i[1], 5'h0});
      ck("sel", {6'h0, i[1:0]}, {6'h0, CLASS_LIMIT_SEL});
      ck("ma", ma[i], CLASS_LIMIT_MA);
    end
    for (p = 1; p < 3; p++) begin
      for (i = 0; i < 5; i++) begin
        wr(3'h2, p[2:0], ld[i]);
        pt(p == 2, 4'h1, lf[i]);
      end
    end
    wr(3'h3, 3'h1, 8'h8f);
    wr(3'h2, 3'h0, 8'h8f);
    wr(3'h2, 3'h3, 8'h8f);
    pt(0, 4'h1, 3'h0);
    pt(1, 4'h1, 3'h0);
    bl(3'h1, 8'h14, 8'h04, 8'h02);
    bl(3'h1, 8'h04, 8'h08, 8'h00);
    bl(3'h2, 8'h18, 8'h0c, 8'h02);
    // Mid-run reset after every field of port three is set
    wr(3'h2, 3'h2, 8'hbf);
    ck("sel", 8'h02, {6'h0, CLASS_LIMIT_SEL});
    ck("ma", 8'h28, CLASS_LIMIT_MA);
    @(posedge CLK_SYS);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
    #1;
    pt(0, 4'h1, 3'h0);
    pt(1, 4'h1, 3'h0);
    ck("sel", 8'h00, {6'h0, CLASS_LIMIT_SEL});
    ck("ma", 8'ha0, CLASS_LIMIT_MA);
    print_verdict;
  end
endmodule // tb
